// ### verilog/rllc_defs.vh
/*
 * rllc_defs.vh: register offsets, field positions, reset values and codes
 * for the remote/local lockout control block.
 * assumes: included by rllc_top.v; holds definitions only.
 */
`ifndef RLLC_DEFS_VH
`define RLLC_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RLLC_OFS_CTRL      12'h000
`define RLLC_OFS_STATUS    12'h004
`define RLLC_OFS_IRQ_STAT  12'h008
`define RLLC_OFS_IRQ_MASK  12'h00c
`define RLLC_OFS_CMD       12'h010

// ****************************************************************
// control register fields
// ****************************************************************
`define RLLC_CTRL_PROT_TRIP   0
`define RLLC_CTRL_RESET       32'h0000_0000

// ****************************************************************
// command register fields (write one to pulse)
// ****************************************************************
`define RLLC_CMD_LISTEN_ADDR  0
`define RLLC_CMD_GTL          1
`define RLLC_CMD_LLO          2
`define RLLC_CMD_UNLISTEN     3
`define RLLC_CMD_DATA         4
`define RLLC_CMD_APPLY        5
`define RLLC_CMD_ADDR_LSB     8
`define RLLC_CMD_ADDR_MSB     12

// ****************************************************************
// status register fields
// ****************************************************************
`define RLLC_ST_REMOTE        0
`define RLLC_ST_LOCKOUT       1
`define RLLC_ST_LISTENER      2
`define RLLC_ST_ACCEPT_ALL    3
`define RLLC_ST_ADDR_VALID    4
`define RLLC_ST_STANDBY       5
`define RLLC_ST_SRQ           6
`define RLLC_ST_ADDR_LSB      8
`define RLLC_ST_ADDR_MSB      12

// ****************************************************************
// interrupt status / mask fields
// ****************************************************************
`define RLLC_IRQ_TO_REMOTE    0
`define RLLC_IRQ_TO_LOCAL     1
`define RLLC_IRQ_LOCKOUT      2
`define RLLC_IRQ_SRQ          3
`define RLLC_IRQ_APPLY        4
`define RLLC_IRQ_WIDTH        5
`define RLLC_IRQ_MASK_RESET   5'h00

// ****************************************************************
// address limits and bus answers
// ****************************************************************
`define RLLC_ADDR_MAX         5'h1e
`define RLLC_RESP_OKAY        2'h0
`define RLLC_RESP_SLVERR      2'h2

`endif

// ### verilog/rllc_top.v
/*
 * rllc_top.v: remote/local lockout control for an instrument's
 * talker/listener port, with an axi4-lite register slave.
 * assumes: one clock aclk at 125 mhz, synchronous active-low aresetn;
 * the bus controller's messages arrive as register commands from the
 * local processor; remote-enable and front switches are raw pins.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
// Contract
// - address from five switches, range 0..30
// - remote enable low blocks standby switch
// - first listen addressing with enable: remote
// - gtl or away switch returns to local
// - after llo ignore manual return request
// - enable released clears lockout, local
// - remote keeps display; meter stays local
// - accept-all select takes all data
// - protection trip in remote raises srq
// - apply parameters on ?, get, cr
`timescale 1ns/1ps
`include "rllc_defs.vh"

module rllc_top
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        remote_enable_n,
   input  wire [4:0]  addr_switch,
   input  wire        accept_all_data_select,
   input  wire        standby_switch,
   input  wire        meter_switch,
   output reg         standby,
   output reg         remote,
   output reg         lockout,
   output reg         display_enable,
   output reg         meter_select,
   output reg         srq,
   output reg         apply_params,
   output reg         data_accept,
   output reg         irq
);

   // ****************************************************************
   // state codes, one-hot
   // ****************************************************************
   localparam [3:0] ST_LOCS = 4'b0001;  // local without lockout
   localparam [3:0] ST_REMS = 4'b0010;  // remote without lockout
   localparam [3:0] ST_LWLS = 4'b0100;  // local with lockout
   localparam [3:0] ST_RWLS = 4'b1000;  // remote with lockout

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   reg [8:0] sync1;           // first stage, read only by sync2
   reg [8:0] sync2;           // second stage, safe to use
   reg       standby_prev;    // previous synced standby switch

   // every pin passes two flops before logic sees it
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= 9'h001;
         sync2 <= 9'h001;
      end
      else
      begin
         sync1 <= {meter_switch, standby_switch, accept_all_data_select,
                   addr_switch, remote_enable_n};
         sync2 <= sync1;
      end
   end

   wire       ren_active  = ~sync2[0];     // remote enable low is active
   wire [4:0] addr_sw     = sync2[5:1];
   wire       accept_all  = sync2[6];
   wire       stby_sw     = sync2[7];
   wire       meter_sw    = sync2[8];
   // switch value 31 is outside the legal range
   // address range check
   wire       addr_valid  = (addr_sw <= `RLLC_ADDR_MAX);
   // away position: rising edge of the standby switch
   wire       rtl_request = stby_sw & ~standby_prev;

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   reg [11:0] wr_addr;        // latched write address
   reg        aw_held;        // address taken, waiting data
   reg [31:0] wr_data;        // latched write data
   reg [3:0]  wr_strb;        // latched byte enables
   reg        w_held;         // data taken, waiting address
   reg [31:0] ctrl;           // control register
   reg [4:0]  irq_stat;       // sticky event bits
   reg [4:0]  irq_mask;       // enables per event
   reg [31:0] cmd_pulse;      // one-cycle controller messages
   reg        wr_fire;        // write executes this cycle

   // takes address and data in either order, answers after both
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RLLC_RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         wr_addr       <= 12'h000;
         wr_data       <= 32'h0000_0000;
         wr_strb       <= 4'h0;
         wr_fire       <= 1'b0;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         wr_fire       <= 1'b0;
         if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid)
         begin
            s_axi_awready <= 1'b1;
            aw_held       <= 1'b1;
            wr_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid)
         begin
            s_axi_wready <= 1'b1;
            w_held       <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
         end
         // both halves in: perform and answer
         if (aw_held && w_held && !wr_fire && !s_axi_bvalid)
         begin
            wr_fire <= 1'b1;
         end
         if (wr_fire)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_addr)
               `RLLC_OFS_CTRL, `RLLC_OFS_IRQ_STAT,
               `RLLC_OFS_IRQ_MASK, `RLLC_OFS_CMD,
               `RLLC_OFS_STATUS : s_axi_bresp <= `RLLC_RESP_OKAY;
               default          : s_axi_bresp <= `RLLC_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // register writes
   // ****************************************************************
   wire       wr_lane0  = wr_fire & wr_strb[0];
   wire       wr_lane1  = wr_fire & wr_strb[1];
   wire [4:0] irq_event;      // events raised this cycle

   // only the low lanes carry bits here; upper lanes are ignored
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl      <= `RLLC_CTRL_RESET;
         irq_mask  <= `RLLC_IRQ_MASK_RESET;
         irq_stat  <= 5'h00;
         cmd_pulse <= 32'h0000_0000;
      end
      else
      begin
         cmd_pulse <= 32'h0000_0000;
         if (wr_lane0 && wr_addr == `RLLC_OFS_CTRL)
            ctrl[7:0] <= wr_data[7:0];
         if (wr_lane0 && wr_addr == `RLLC_OFS_IRQ_MASK)
            irq_mask <= wr_data[4:0];
         if (wr_addr == `RLLC_OFS_CMD && wr_lane0 && wr_lane1)
            cmd_pulse <= {16'h0000, wr_data[15:0]};
         // set wins over write-one-to-clear in the same cycle
         if (wr_lane0 && wr_addr == `RLLC_OFS_IRQ_STAT)
            irq_stat <= (irq_stat & ~wr_data[4:0]) | irq_event;
         else
            irq_stat <= irq_stat | irq_event;
      end
   end

   // ****************************************************************
   // controller messages decoded from command pulses
   // ****************************************************************
   wire [4:0] cmd_addr   = cmd_pulse[`RLLC_CMD_ADDR_MSB:`RLLC_CMD_ADDR_LSB];
   // addressed as listener only when the address matches our switches
   wire       listen_hit = cmd_pulse[`RLLC_CMD_LISTEN_ADDR] & addr_valid &
                           (cmd_addr == addr_sw);
   wire       gtl_cmd    = cmd_pulse[`RLLC_CMD_GTL];
   wire       llo_cmd    = cmd_pulse[`RLLC_CMD_LLO];
   wire       unl_cmd    = cmd_pulse[`RLLC_CMD_UNLISTEN];

   // ****************************************************************
   // remote/local state machine
   // ****************************************************************
   reg [3:0] rl_state;        // current one-hot state
   reg [3:0] next_rl_state;   // combinational next state
   reg       listener;        // listener addressing recorded

   // transitions; lockout can only be left by releasing enable
   always @*
   begin
      next_rl_state = rl_state;
      case (rl_state)
         ST_LOCS :
         begin
            if (ren_active && listen_hit)
               next_rl_state = llo_cmd ? ST_RWLS : ST_REMS;
            else if (ren_active && llo_cmd)
               next_rl_state = ST_LWLS;
         end
         ST_REMS :
         begin
            if (gtl_cmd || rtl_request)
               next_rl_state = ST_LOCS;
            else if (llo_cmd)
               next_rl_state = ST_RWLS;
         end
         ST_LWLS :
         begin
            if (listen_hit)
               next_rl_state = ST_RWLS;
         end
         ST_RWLS :
         begin
            if (gtl_cmd)
               next_rl_state = ST_LWLS;
         end
         default :
            next_rl_state = ST_LOCS;
      endcase
      if (!ren_active)
         next_rl_state = ST_LOCS;
   end

   wire in_remote = rl_state[1] | rl_state[3];
   wire trip      = ctrl[`RLLC_CTRL_PROT_TRIP];
   reg  trip_prev;            // previous trip level for edge detect

   // state register and all registered outputs except the axi4-lite ones
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rl_state       <= ST_LOCS;
         listener       <= 1'b0;
         standby_prev   <= 1'b0;
         standby        <= 1'b0;
         remote         <= 1'b0;
         lockout        <= 1'b0;
         display_enable <= 1'b1;
         meter_select   <= 1'b0;
         srq            <= 1'b0;
         apply_params   <= 1'b0;
         data_accept    <= 1'b0;
         trip_prev      <= 1'b0;
      end
      else
      begin
         rl_state     <= next_rl_state;
         standby_prev <= stby_sw;
         trip_prev    <= trip;
         if (listen_hit)
            listener <= 1'b1;
         else if (unl_cmd || !ren_active)
            listener <= 1'b0;
         if (!ren_active)
            standby <= stby_sw;
         remote  <= next_rl_state[1] | next_rl_state[3];
         lockout <= next_rl_state[2] | next_rl_state[3];
         display_enable <= 1'b1;
         meter_select   <= meter_sw;
         if (trip && in_remote)
            srq <= 1'b1;
         else if (!trip || !in_remote)
            srq <= 1'b0;
         apply_params <= cmd_pulse[`RLLC_CMD_APPLY] & (listener | accept_all);
         data_accept  <= cmd_pulse[`RLLC_CMD_DATA] & (listener | accept_all);
         irq <= |(irq_stat & irq_mask);
      end
   end

   // interrupt events from state changes, trips and accepted apply commands
   assign irq_event[`RLLC_IRQ_TO_REMOTE] = ~in_remote &
                                           (next_rl_state[1] | next_rl_state[3]);
   assign irq_event[`RLLC_IRQ_TO_LOCAL]  = in_remote &
                                           (next_rl_state[0] | next_rl_state[2]);
   assign irq_event[`RLLC_IRQ_LOCKOUT]   = (rl_state[0] | rl_state[1]) &
                                           (next_rl_state[2] | next_rl_state[3]);
   assign irq_event[`RLLC_IRQ_SRQ]       = trip & ~trip_prev & in_remote;
   assign irq_event[`RLLC_IRQ_APPLY]     = cmd_pulse[`RLLC_CMD_APPLY] &
                                           (listener | accept_all);

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   wire [31:0] status_word = {19'h00000, addr_sw, 1'b0, srq, standby,
                              addr_valid, accept_all, listener,
                              lockout, remote};

   // one read at a time; answer one cycle after the address, together with arready
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RLLC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RLLC_RESP_OKAY;
            case (s_axi_araddr)
               `RLLC_OFS_CTRL     : s_axi_rdata <= ctrl;
               `RLLC_OFS_STATUS   : s_axi_rdata <= status_word;
               `RLLC_OFS_IRQ_STAT : s_axi_rdata <= {27'h0000000, irq_stat};
               `RLLC_OFS_IRQ_MASK : s_axi_rdata <= {27'h0000000, irq_mask};
               `RLLC_OFS_CMD      : s_axi_rdata <= 32'h0000_0000;
               default :
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RLLC_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ### verification/rllc_checker.sv
/* rllc_checker.sv: port-level assertions for rllc_top.
   assumes: bound onto rllc_top; one clock aclk, sync active-low aresetn. */
`timescale 1ns/1ps
module rllc_checker
(
   input wire aclk,
   input wire aresetn,
   input wire remote_enable_n,
   input wire meter_switch,
   input wire standby,
   input wire remote,
   input wire lockout,
   input wire display_enable,
   input wire meter_select,
   input wire srq,
   input wire apply_params,
   input wire data_accept,
   input wire irq
);
   // ********
   // properties, all in the aclk domain
   // ********
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_clean: assert property ($rose(aresetn) |-> !remote && !lockout && !srq)
      else $error("outputs not idle at reset release");
   a_standby_held: assert property ((!remote_enable_n) [*4] |=> $stable(standby))
      else $error("standby moved while enable low");
   a_release_local: assert property (remote_enable_n [*4] |-> !remote && !lockout)
      else $error("remote or lockout kept after enable release");
   a_display_on: assert property (remote |-> display_enable)
      else $error("display off in remote");
   // meter under local switch; three-flop path, hence the reset guard
   a_meter_local: assert property ($past(aresetn, 3) |-> meter_select == $past(meter_switch, 3))
      else $error("meter select does not follow switch");
   a_srq_remote: assert property (srq |-> remote || $past(remote))
      else $error("service request outside remote");
   a_apply_single: assert property (apply_params |=> !apply_params)
      else $error("apply pulse longer than one cycle");
   a_data_single: assert property (data_accept |=> !data_accept)
      else $error("data accept pulse longer than one cycle");
   // main scenarios reached
   c_to_remote: cover property ($rose(remote));
   c_remote_lock: cover property (remote && lockout);
   c_irq_seen: cover property ($rose(irq));
endmodule

bind rllc_top rllc_checker u_rllc_checker (.aclk(aclk), .aresetn(aresetn),
   .remote_enable_n(remote_enable_n), .meter_switch(meter_switch), .standby(standby),
   .remote(remote), .lockout(lockout), .display_enable(display_enable),
   .meter_select(meter_select), .srq(srq), .apply_params(apply_params),
   .data_accept(data_accept), .irq(irq));

// ### verification/rllc_ctl_model.sv
/* rllc_ctl_model.sv: behavioural bus controller holding the remote-enable line.
   assumes: the bench sends listen, gtl and llo through the command register. */
`timescale 1ns/1ps
module rllc_ctl_model
(
   input  wire aclk,
   output reg  remote_enable_n
);
   // line passive high until the controller takes the bus
   initial remote_enable_n = 1'b1;
   // hold or release
   // changed just after an edge, held until the next call
   task drive(input en);
      @(posedge aclk);
      remote_enable_n <= ~en;
   endtask
endmodule

// ### verification/tb_remote_local_lockout_control.sv
/* tb_remote_local_lockout_control.sv: self-checking bench for rllc_top.
   assumes: bench is the axi4-lite master; rllc_ctl_model owns the enable line. */
`timescale 1ns/1ps
`include "rllc_defs.vh"
module tb_remote_local_lockout_control;
   // ********
   // signals and instances
   // ********
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire [3:0]  s_axi_wstrb = 4'hf;  // whole words only
   reg  [4:0]  addr_switch = 5'h1e;  // top of the legal range
   reg         accept_all_data_select = 1'b0, standby_switch = 1'b0, meter_switch = 1'b0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        remote_enable_n, standby, remote, lockout, display_enable;
   wire        meter_select, srq, apply_params, data_accept, irq;
   integer     failures = 0, tests_run = 0, n_apply = 0, n_data = 0;
   reg  [31:0] rv;  // last read data
   reg  [1:0]  resp;  // last response code
   always #4 aclk = ~aclk;
   // pulses are counted, not caught, so their exact cycle does not matter
   always @(posedge aclk)
   begin
      if (apply_params === 1'b1)
         n_apply <= n_apply + 1;
      if (data_accept === 1'b1)
         n_data <= n_data + 1;
   end
   rllc_top u_rllc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remote_enable_n, .addr_switch,
      .accept_all_data_select, .standby_switch, .meter_switch, .standby, .remote, .lockout,
      .display_enable, .meter_select, .srq, .apply_params, .data_accept, .irq);
   rllc_ctl_model u_rllc_ctl_model (.aclk, .remote_enable_n);
   // ********
   // tasks and test sequence
   // ********
   task give_verdict;
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task check(input string n, input [31:0] e, input [31:0] g);
      tests_run = tests_run + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // a wait that runs out counts as a failure and closes the run
   task tmo(input integer i);
      if (i >= 40)
      begin
         failures = failures + 1;
         give_verdict;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   task rl(input [1:0] e);
      check("remote_lockout", e, {remote, lockout});
   endtask
   // address and data offered together, each dropped once taken
   // pending flags, since a valid raised by nba still reads low here
   task wr(input [11:0] a, input [31:0] d);
      integer i;
      reg     aw_go;
      reg     w_go;
      aw_go = 1'b1;
      w_go = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 40 && (aw_go || w_go); i = i + 1)
      begin
         @(posedge aclk);
         if (aw_go && s_axi_awready === 1'b1)
         begin
            aw_go = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_go && s_axi_wready === 1'b1)
         begin
            w_go = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      tmo(i);
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40 && s_axi_bvalid !== 1'b1; i = i + 1)
         @(posedge aclk);
      tmo(i);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [11:0] a);
      integer i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40 && s_axi_rvalid !== 1'b1; i = i + 1)
         @(posedge aclk);
      tmo(i);
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask
   // command pulse, then one edge for state and one spare
   task cmd(input [31:0] d);
      wr(`RLLC_OFS_CMD, d);
      cyc(2);
   endtask
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rl(2'h0);
      // switch pins need two edges through the synchroniser
      cyc(2);
      rd(`RLLC_OFS_STATUS);
      check("listener", 32'h0, rv[2]);
      check("address", 32'h1e10, rv & 32'h1f10);
      // enable released: standby follows, listen ignored
      standby_switch <= 1'b1;
      cyc(4);
      check("standby", 32'h1, standby);
      standby_switch <= 1'b0;
      cmd(32'h1e01);
      rl(2'h0);
      u_rllc_ctl_model.drive(1'b1);
      cyc(4);
      standby_switch <= 1'b1;
      cyc(4);
      check("standby", 32'h0, standby);
      standby_switch <= 1'b0;
      cmd(32'h1d01);
      rl(2'h0);
      cmd(32'h1e01);
      rl(2'h2);
      // interrupt raised, masked, unmasked, cleared
      rd(`RLLC_OFS_IRQ_STAT);
      check("irq_stat", 32'h1, rv[0]);
      check("irq", 32'h0, irq);
      wr(`RLLC_OFS_IRQ_MASK, 32'h1);
      cyc(2);
      check("irq", 32'h1, irq);
      wr(`RLLC_OFS_IRQ_STAT, 32'h1);
      cyc(2);
      check("irq", 32'h0, irq);
      // meter local, display on, trip raises request
      meter_switch <= 1'b1;
      wr(`RLLC_OFS_CTRL, 32'h1);
      cyc(2);
      check("meter", 32'h1, meter_select);
      check("display", 32'h1, display_enable);
      check("srq", 32'h1, srq);
      cmd(32'h2);
      rl(2'h0);
      check("srq", 32'h0, srq);
      wr(`RLLC_OFS_CTRL, 32'h0);
      cmd(32'h1e01);
      standby_switch <= 1'b1;
      cyc(4);
      rl(2'h0);
      check("standby", 32'h0, standby);
      standby_switch <= 1'b0;
      // lockout: manual return refused, gtl still obeyed
      cmd(32'h1e01);
      cmd(32'h4);
      standby_switch <= 1'b1;
      cyc(4);
      rl(2'h3);
      standby_switch <= 1'b0;
      cmd(32'h2);
      rl(2'h1);
      cmd(32'h1e01);
      rl(2'h3);
      u_rllc_ctl_model.drive(1'b0);
      cyc(4);
      rl(2'h0);
      // data and apply, unaddressed with and without accept-all, then apply when addressed
      accept_all_data_select <= 1'b1;
      cyc(4);
      cmd(32'h10);
      cmd(32'h20);
      accept_all_data_select <= 1'b0;
      cyc(4);
      cmd(32'h10);
      cmd(32'h20);
      check("data_count", 32'h1, n_data);
      check("apply_count", 32'h1, n_apply);
      u_rllc_ctl_model.drive(1'b1);
      cyc(4);
      cmd(32'h1e01);
      cmd(32'h20);
      check("apply_count", 32'h2, n_apply);
      // unmapped address refused both ways
      wr(12'h100, 32'h1);
      check("bresp", `RLLC_RESP_SLVERR, resp);
      rd(12'h100);
      check("rresp", `RLLC_RESP_SLVERR, resp);
      check("rdata", 32'h0, rv);
      give_verdict;
   end
endmodule
